// [hdl/ops_defs.svh]
// Timing counts and level constants for the offline PWM sequencer.
`ifndef OPS_DEFS_SVH
`define OPS_DEFS_SVH

`define OPS_CLK_MHZ         100
`define OPS_SW_FREQ_KHZ     60
`define OPS_SW_PERIOD_CYC   ((`OPS_CLK_MHZ * 1000) / `OPS_SW_FREQ_KHZ)
`define OPS_JITTER_SPAN     64
`define OPS_MAX_ON_PCT      75
`define OPS_SS_STEPS        16
`define OPS_SS_TOTAL_US     8500
`define OPS_SS_STEP_CYC     ((`OPS_SS_TOTAL_US * `OPS_CLK_MHZ) / `OPS_SS_STEPS)
`define OPS_SC_PERSIST_MS   50
`define OPS_SC_PERSIST_CYC  (`OPS_SC_PERSIST_MS * 1000 * `OPS_CLK_MHZ)
`define OPS_RESTART_MS      1000
`define OPS_RESTART_CYC     (`OPS_RESTART_MS * 1000 * `OPS_CLK_MHZ)
`define OPS_LIMIT_BITS      4
`define OPS_LIMIT_FULL      4'hF
`define OPS_LIMIT_BURST     4'h3

`endif

// [hdl/ops_pkg.sv]
// Types shared by the offline PWM sequencer.
package ops_pkg;

   typedef enum logic [2:0] {
      OPS_CHARGE  = 3'b000,
      OPS_SOFT    = 3'b001,
      OPS_RUN     = 3'b010,
      OPS_BURST   = 3'b011,
      OPS_RESTART = 3'b100
   } ops_state_t;

endpackage : ops_pkg

// [hdl/ops_sync.sv]
// Two-flop synchroniser for a group of comparator results.
`timescale 1ns/1ns
`default_nettype none

module ops_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] meta_q;

   // Each bit passes two flops; only the second flop is read downstream.
   genvar i;
   for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            meta_q[i]  <= 1'b0;
            syncOut[i] <= 1'b0;
         end else begin
            meta_q[i]  <= asyncIn[i];
            syncOut[i] <= meta_q[i];
         end
      end
   end

endmodule : ops_sync

`default_nettype wire

// [hdl/ops_sequencer.sv]
// Control sequencer of an offline current-mode converter: startup, soft-start, PWM, burst, faults.
`timescale 1ns/1ns
`default_nettype none
`include "ops_defs.svh"

module ops_sequencer #(
   parameter int SW_PERIOD_CYC  = `OPS_SW_PERIOD_CYC,
   parameter int SS_STEP_CYC    = `OPS_SS_STEP_CYC,
   parameter int SC_PERSIST_CYC = `OPS_SC_PERSIST_CYC,
   parameter int RESTART_CYC    = `OPS_RESTART_CYC
) (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       supplyAtTurnOn,
   input  wire logic       supplyAtLow,
   input  wire logic       pwmCompareTrip,
   input  wire logic       overcurrentComparator,
   input  wire logic       errorAmpSaturated,
   input  wire logic       errorAmpBelowBurst,
   input  wire logic       errorAmpAboveBurstHyst,
   input  wire logic       clampFaultCurrent,
   input  wire logic       shortCircuitDetect,
   output logic            startupChargeEnable,
   output logic            gateDrive,
   output logic [3:0]      peakCurrentLimit,
   output logic            burstActive,
   output logic            faultRestart
);

   localparam int CW = 34;

   logic [7:0] cmpSync;
   logic       vOn;
   logic       vLow;
   logic       pwmTrip;
   logic       ocTrip;
   logic       eaSat;
   logic       eaBurst;
   logic       eaResume;
   logic       clampHigh;
   logic       scDet;

   ops_pkg::ops_state_t state_q;
   logic [CW-1:0]       timer_q;
   logic [CW-1:0]       scCount_q;
   logic [3:0]          ssStep_q;
   logic [15:0]         cycCount_q;
   logic [15:0]         period_q;
   logic [5:0]          lfsr_q;
   logic                everOn_q;
   logic                onPhase_q;
   logic                burstOn_q;
   logic                switching;
   logic                clampFault;
   logic                scFault;
   logic                cycleStart;
   logic [15:0]         maxOn;

   // Every comparator result crosses into the clock domain first.
   ops_sync #(
      .WIDTH (8)
   ) u_sync (
      .clk     (clk),
      .resetn  (resetn),
      .asyncIn ({supplyAtTurnOn, supplyAtLow, pwmCompareTrip, overcurrentComparator,
                 errorAmpSaturated, errorAmpBelowBurst, errorAmpAboveBurstHyst,
                 clampFaultCurrent}),
      .syncOut (cmpSync)
   );

   assign {vOn, vLow, pwmTrip, ocTrip, eaSat, eaBurst, eaResume, clampHigh} = cmpSync;

   // The short-circuit flag also comes from an analogue sense, so it is synchronised too.
   ops_sync #(
      .WIDTH (1)
   ) u_sync_sc (
      .clk     (clk),
      .resetn  (resetn),
      .asyncIn (shortCircuitDetect),
      .syncOut (scDet)
   );

   // Clamp fault needs the current limit and the clamp current at once.
   assign clampFault = ocTrip && clampHigh && switching;
   assign scFault    = (scCount_q >= CW'(SC_PERSIST_CYC - 1)) && scDet;

   // Switching states. In burst the pulses follow the hysteresis flop, and a fresh drop
   // below the threshold masks the gate at once instead of waiting a cycle for the flop.
   assign switching  = (state_q == ops_pkg::OPS_SOFT) || (state_q == ops_pkg::OPS_RUN)
                       || (state_q == ops_pkg::OPS_BURST && burstOn_q && !eaBurst);

   // Supply hysteresis: the source charges until turn-on and restarts at the low level,
   // so during a fault the supply keeps cycling between the two levels.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         startupChargeEnable <= 1'b1;
      end else if (vOn) begin
         startupChargeEnable <= 1'b0;
      end else if (vLow) begin
         startupChargeEnable <= 1'b1;
      end
   end

   // Remembers that the turn-on threshold was reached once; only lockout reset clears it.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         everOn_q <= 1'b0;
      end else if (vOn) begin
         everOn_q <= 1'b1;
      end
   end

   // Burst hysteresis: pulses stop below the burst threshold and return only above
   // threshold plus hysteresis, so a level near the threshold cannot chatter the switch.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         burstOn_q <= 1'b0;
      end else if (state_q != ops_pkg::OPS_BURST || eaBurst) begin
         burstOn_q <= 1'b0;
      end else if (eaResume) begin
         burstOn_q <= 1'b1;
      end
   end

   // Main sequence. Lockout acts as reset, so the sequence only returns to OPS_CHARGE below it.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= ops_pkg::OPS_CHARGE;
      end else begin
         case (state_q)
            ops_pkg::OPS_CHARGE: begin
               if (vOn) begin
                  state_q <= ops_pkg::OPS_SOFT;
               end
            end
            ops_pkg::OPS_SOFT: begin
               if (scFault || clampFault) begin
                  state_q <= ops_pkg::OPS_RESTART;
               end else if (ssStep_q == 4'hF && timer_q >= CW'(SS_STEP_CYC - 1)) begin
                  state_q <= ops_pkg::OPS_RUN;
               end
            end
            ops_pkg::OPS_RUN: begin
               if (scFault || clampFault) begin
                  state_q <= ops_pkg::OPS_RESTART;
               end else if (eaBurst) begin
                  state_q <= ops_pkg::OPS_BURST;
               end
            end
            ops_pkg::OPS_BURST: begin
               if (scFault || clampFault) begin
                  state_q <= ops_pkg::OPS_RESTART;
               end else if (eaSat) begin
                  state_q <= ops_pkg::OPS_RUN;
               end
            end
            ops_pkg::OPS_RESTART: begin
               if (timer_q >= CW'(RESTART_CYC - 1)) begin
                  state_q <= ops_pkg::OPS_SOFT;
               end
            end
            default: begin
               state_q <= ops_pkg::OPS_CHARGE;
            end
         endcase
      end
   end

   // Shared timer: soft-start step time and the 1 s restart hold.
   // A fault clears it in soft-start, so the hold always counts from zero.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         timer_q <= '0;
      end else if (state_q == ops_pkg::OPS_SOFT) begin
         if (scFault || clampFault || timer_q >= CW'(SS_STEP_CYC - 1)) begin
            timer_q <= '0;
         end else begin
            timer_q <= timer_q + 1'b1;
         end
      end else if (state_q == ops_pkg::OPS_RESTART) begin
         if (timer_q >= CW'(RESTART_CYC - 1)) begin
            timer_q <= '0;
         end else begin
            timer_q <= timer_q + 1'b1;
         end
      end else begin
         timer_q <= '0;
      end
   end

   // Soft-start step index; each restart begins again from the lowest step.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ssStep_q <= 4'h0;
      end else if (state_q != ops_pkg::OPS_SOFT) begin
         ssStep_q <= 4'h0;
      end else if (timer_q >= CW'(SS_STEP_CYC - 1) && ssStep_q != 4'hF) begin
         ssStep_q <= ssStep_q + 4'h1;
      end
   end

   // Short-circuit persistence counter; any gap in the condition starts it over.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         scCount_q <= '0;
      end else if (!scDet || !switching) begin
         scCount_q <= '0;
      end else if (scCount_q < CW'(SC_PERSIST_CYC - 1)) begin
         scCount_q <= scCount_q + 1'b1;
      end
   end

   // Active current limit: soft-start steps, full limit in run, burst clamp.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         peakCurrentLimit <= 4'h0;
      end else begin
         case (state_q)
            ops_pkg::OPS_SOFT:  peakCurrentLimit <= ssStep_q;
            ops_pkg::OPS_RUN:   peakCurrentLimit <= `OPS_LIMIT_FULL;
            ops_pkg::OPS_BURST: peakCurrentLimit <= `OPS_LIMIT_BURST;
            default:            peakCurrentLimit <= 4'h0;
         endcase
      end
   end

   // Jitter source: a small LFSR spreads the period to smear emissions.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lfsr_q <= 6'h01;
      end else if (cycleStart) begin
         lfsr_q <= {lfsr_q[4:0], lfsr_q[5] ^ lfsr_q[4]};
      end
   end

   // Cycle boundary and duty cap; the cap leaves the core time to reset every cycle.
   assign cycleStart = (cycCount_q >= period_q - 16'h0001);
   assign maxOn      = 16'((32'(period_q) * `OPS_MAX_ON_PCT) / 100);

   // Oscillator counter and next period; centre is 60 kHz, spread is a few percent.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cycCount_q <= 16'h0000;
         period_q   <= 16'(SW_PERIOD_CYC);
      end else if (cycleStart) begin
         cycCount_q <= 16'h0000;
         period_q   <= 16'(SW_PERIOD_CYC - (`OPS_JITTER_SPAN / 2)) + {10'h000, lfsr_q};
      end else begin
         cycCount_q <= cycCount_q + 16'h0001;
      end
   end

   // On-time: set at cycle start, ended by PWM compare, current limit or maximum duty.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         onPhase_q <= 1'b0;
      end else if (cycleStart) begin
         onPhase_q <= switching && everOn_q;
      end else if (pwmTrip) begin
         onPhase_q <= 1'b0;
      end else if (ocTrip) begin
         onPhase_q <= 1'b0;
      end else if (cycCount_q >= maxOn || !switching) begin
         onPhase_q <= 1'b0;
      end
   end

   // Gate output from a flop; a trip in the same cycle blocks the drive at once.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         gateDrive <= 1'b0;
      end else begin
         gateDrive <= onPhase_q && !pwmTrip && !ocTrip && switching;
      end
   end

   // Status outputs for the analogue side and observation.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         burstActive  <= 1'b0;
         faultRestart <= 1'b0;
      end else begin
         burstActive  <= (state_q == ops_pkg::OPS_BURST);
         faultRestart <= (state_q == ops_pkg::OPS_RESTART);
      end
   end

endmodule : ops_sequencer

`default_nettype wire

// [bench/ops_seq_props.sv]
// Port-level assertions for the offline PWM sequencer.
`timescale 1ns/1ns
`default_nettype none
`include "ops_defs.svh"
module ops_seq_props #(
   parameter int SW_PERIOD_CYC = 100,
   parameter int RESTART_CYC   = 300
) (
   input wire logic       clk,
   input wire logic       resetn,
   input wire logic       supplyAtTurnOn,
   input wire logic       supplyAtLow,
   input wire logic       pwmCompareTrip,
   input wire logic       overcurrentComparator,
   input wire logic       errorAmpBelowBurst,
   input wire logic       startupChargeEnable,
   input wire logic       gateDrive,
   input wire logic [3:0] peakCurrentLimit,
   input wire logic       burstActive,
   input wire logic       faultRestart
);
   int holdCnt;
   int perCnt;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // Length of the current restart hold.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) holdCnt <= 0;
      else holdCnt <= faultRestart ? holdCnt + 1 : 0;
   end
   // Cycles since the last gate rise; jitter moves a period by at most 31 either way.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) perCnt <= 0;
      else perCnt <= $rose(gateDrive) ? 1 : perCnt + 1;
   end
   hold_gate_off_a: assert property (faultRestart |-> !gateDrive)
      else $error("gate on during restart hold");
   hold_length_a: assert property ($fell(faultRestart) |-> holdCnt >= RESTART_CYC - 1
      && holdCnt <= RESTART_CYC + 1) else $error("restart hold has wrong length");
   pwm_ends_on_a: assert property (pwmCompareTrip [*3] |=> !gateDrive)
      else $error("on-time outlived the PWM trip");
   oc_ends_on_a: assert property (overcurrentComparator [*3] |=> !gateDrive)
      else $error("on-time outlived the current limit");
   charge_stop_a: assert property ($fell(startupChargeEnable) |-> $past(supplyAtTurnOn, 3))
      else $error("charge source stopped without turn-on level");
   charge_resume_a: assert property ($rose(startupChargeEnable) |-> $past(supplyAtLow, 3))
      else $error("charge source resumed without low level");
   burst_limit_a: assert property (burstActive && $past(burstActive) |->
      peakCurrentLimit == `OPS_LIMIT_BURST) else $error("burst limit not applied");
   burst_no_gate_a: assert property (errorAmpBelowBurst [*4] ##0 burstActive |-> !gateDrive)
      else $error("switching while below burst threshold");
   limit_steps_a: assert property ($changed(peakCurrentLimit) |-> peakCurrentLimit == 4'h0
      || peakCurrentLimit == $past(peakCurrentLimit) + 4'h1
      || peakCurrentLimit == `OPS_LIMIT_BURST || peakCurrentLimit == `OPS_LIMIT_FULL)
      else $error("limit skipped a soft-start step");
   period_min_a: assert property ($rose(gateDrive) |-> perCnt >= SW_PERIOD_CYC - 32)
      else $error("switching period too short");
   cover property ($fell(faultRestart));
   cover property ($rose(burstActive));
   cover property (peakCurrentLimit == `OPS_LIMIT_FULL && gateDrive);
endmodule : ops_seq_props
bind ops_sequencer ops_seq_props #(.SW_PERIOD_CYC(SW_PERIOD_CYC), .RESTART_CYC(RESTART_CYC))
   chk_u (.clk(clk), .resetn(resetn), .supplyAtTurnOn(supplyAtTurnOn),
   .supplyAtLow(supplyAtLow), .pwmCompareTrip(pwmCompareTrip),
   .overcurrentComparator(overcurrentComparator), .errorAmpBelowBurst(errorAmpBelowBurst),
   .startupChargeEnable(startupChargeEnable), .gateDrive(gateDrive),
   .peakCurrentLimit(peakCurrentLimit), .burstActive(burstActive),
   .faultRestart(faultRestart));
`default_nettype wire

// [bench/ops_power_stage.sv]
// Behavioural power switch, current sense and feedback network.
`timescale 1ns/1ns
`default_nettype none
module ops_power_stage (
   input  wire logic       clk,
   input  wire logic       gateDrive,
   input  wire logic [3:0] peakCurrentLimit,
   input  wire logic [7:0] errorLevel,
   output logic            pwmCompareTrip,
   output logic            overcurrentComparator
);
   logic [7:0] primaryCurrent;
   // Current ramps while the switch conducts and is gone once it opens.
   always_ff @(posedge clk) begin
      primaryCurrent <= gateDrive ? primaryCurrent + 8'h01 : 8'h00;
   end
   // Error input is grounded, so errorLevel stands for the optocoupler drive.
   assign pwmCompareTrip        = gateDrive && (primaryCurrent > errorLevel);
   assign overcurrentComparator = gateDrive && (primaryCurrent >= {3'h0, peakCurrentLimit, 1'b0} + 8'h02);
endmodule : ops_power_stage
`default_nettype wire

// [bench/offline_pwm_sequencer_test.sv]
// Self-checking bench for the offline PWM sequencer.
`timescale 1ns/1ns
`default_nettype none
`include "ops_defs.svh"
module offline_pwm_sequencer_test;
   localparam int SS = 200;
   localparam int RH = 300;
   logic       clk = 1'b0;
   logic       resetn, supplyAtTurnOn, supplyAtLow, pwmCompareTrip, overcurrentComparator;
   logic       errorAmpSaturated, errorAmpBelowBurst, errorAmpAboveBurstHyst;
   logic       clampFaultCurrent, shortCircuitDetect, startupChargeEnable, gateDrive;
   logic       burstActive, faultRestart;
   logic [3:0] peakCurrentLimit;
   logic [7:0] errorLevel;
   int         miscompares = 0;
   int         testsRun = 0;
   ops_sequencer #(.SW_PERIOD_CYC(100), .SS_STEP_CYC(SS), .SC_PERSIST_CYC(50),
      .RESTART_CYC(RH)) dut_u (.clk(clk), .resetn(resetn), .supplyAtTurnOn(supplyAtTurnOn),
      .supplyAtLow(supplyAtLow), .pwmCompareTrip(pwmCompareTrip),
      .overcurrentComparator(overcurrentComparator), .errorAmpSaturated(errorAmpSaturated),
      .errorAmpBelowBurst(errorAmpBelowBurst), .errorAmpAboveBurstHyst(errorAmpAboveBurstHyst),
      .clampFaultCurrent(clampFaultCurrent), .shortCircuitDetect(shortCircuitDetect),
      .startupChargeEnable(startupChargeEnable), .gateDrive(gateDrive),
      .peakCurrentLimit(peakCurrentLimit), .burstActive(burstActive), .faultRestart(faultRestart));
   ops_power_stage stage_u (.clk(clk), .gateDrive(gateDrive), .peakCurrentLimit(peakCurrentLimit),
      .errorLevel(errorLevel), .pwmCompareTrip(pwmCompareTrip),
      .overcurrentComparator(overcurrentComparator));
   // Free-running 100 MHz clock.
   always #5 clk = ~clk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      testsRun++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", testsRun, miscompares);
      if (miscompares == 0 && testsRun > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   // Length of the next complete gate pulse; bounded so a stuck gate cannot hang.
   task automatic on_time(output int n);
      n = 0;
      for (int i = 0; i < 300 && gateDrive !== 1'b0; i++) @(posedge clk);
      for (int i = 0; i < 300 && gateDrive !== 1'b1; i++) @(posedge clk);
      while (gateDrive === 1'b1 && n < 300) begin
         @(posedge clk);
         n++;
      end
   endtask : on_time
   task automatic startup_t();
      check(startupChargeEnable, 1);
      check(gateDrive, 0);
      supplyAtTurnOn <= 1'b1;
      for (int i = 0; i < 20 && startupChargeEnable !== 1'b0; i++) @(posedge clk);
      check(startupChargeEnable, 0);
      for (int i = 0; i < 300 && gateDrive !== 1'b1; i++) @(posedge clk);
      check(gateDrive, 1);
      check(peakCurrentLimit, 0);
   endtask : startup_t
   // Every step between the first and the last is watched whole, so its length must be exact.
   task automatic soft_t();
      int n;
      for (int s = 1; s < 16; s++) begin
         n = 0;
         while (peakCurrentLimit === 4'(s - 1) && n < 2 * SS) begin
            @(posedge clk);
            n++;
         end
         check(peakCurrentLimit, s);
         if (s > 1) check(n, SS);
      end
   endtask : soft_t
   task automatic loop_t();
      int a;
      int b;
      on_time(a);
      errorLevel <= 8'h0A;
      cyc(2);
      on_time(b);
      check(a >= 32 && a <= 36, 1);
      check(b >= 10 && b <= 15, 1);
      errorLevel <= 8'hFF;
   endtask : loop_t
   task automatic supply_t();
      int a;
      supplyAtTurnOn <= 1'b0;
      supplyAtLow <= 1'b1;
      cyc(6);
      check(startupChargeEnable, 1);
      on_time(a);
      check(a > 0, 1);
      supplyAtLow <= 1'b0;
      supplyAtTurnOn <= 1'b1;
      cyc(6);
      check(startupChargeEnable, 0);
   endtask : supply_t
   task automatic burst_t();
      int n = 0;
      errorAmpSaturated <= 1'b0;
      errorAmpBelowBurst <= 1'b1;
      for (int i = 0; i < 300 && burstActive !== 1'b1; i++) @(posedge clk);
      check(burstActive, 1);
      cyc(2);
      check(peakCurrentLimit, `OPS_LIMIT_BURST);
      errorAmpBelowBurst <= 1'b0;
      repeat (300) begin
         @(posedge clk);
         n += int'(gateDrive === 1'b1);
      end
      check(n, 0);
      errorAmpAboveBurstHyst <= 1'b1;
      for (int i = 0; i < 300 && gateDrive !== 1'b1; i++) @(posedge clk);
      check(gateDrive, 1);
      errorAmpSaturated <= 1'b1;
      cyc(300);
      check(burstActive, 0);
      check(peakCurrentLimit, `OPS_LIMIT_FULL);
   endtask : burst_t
   // Hold length, then a fresh soft-start from the lowest limit.
   task automatic restart_t();
      int n = 0;
      while (faultRestart === 1'b1 && n < 2 * RH) begin
         @(posedge clk);
         n++;
      end
      check(n >= RH - 1 && n <= RH + 1, 1);
      for (int i = 0; i < 300 && gateDrive !== 1'b1; i++) @(posedge clk);
      check(peakCurrentLimit, 0);
      soft_t();
      cyc(50);
   endtask : restart_t
   task automatic short_t();
      int n = 0;
      shortCircuitDetect <= 1'b1;
      cyc(30);
      shortCircuitDetect <= 1'b0;
      cyc(60);
      check(faultRestart, 0);
      shortCircuitDetect <= 1'b1;
      while (faultRestart !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      check(n >= 50 && n <= 56, 1);
      shortCircuitDetect <= 1'b0;
      restart_t();
   endtask : short_t
   task automatic clamp_t();
      errorLevel <= 8'h0A;
      // Let a pulse begun under the old level end before the clamp flag rises.
      cyc(8);
      clampFaultCurrent <= 1'b1;
      cyc(400);
      check(faultRestart, 0);
      errorLevel <= 8'hFF;
      for (int i = 0; i < 400 && faultRestart !== 1'b1; i++) @(posedge clk);
      check(faultRestart, 1);
      clampFaultCurrent <= 1'b0;
      restart_t();
   endtask : clamp_t
   // Hang guard, well beyond the roughly 12000 cycles the run needs.
   initial begin
      #400000;
      miscompares++;
      wrap_up();
   end
   // Reset, then the scenarios in order; each after startup_t leaves the converter at the full current limit.
   initial begin
      {resetn, supplyAtTurnOn, supplyAtLow, errorAmpBelowBurst} = 4'h0;
      {errorAmpAboveBurstHyst, clampFaultCurrent, shortCircuitDetect} = 3'h0;
      errorAmpSaturated = 1'b1;
      errorLevel = 8'hFF;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      cyc(100);
      startup_t();
      soft_t();
      loop_t();
      supply_t();
      burst_t();
      short_t();
      clamp_t();
      wrap_up();
   end
endmodule : offline_pwm_sequencer_test
`default_nettype wire
